// ### rtl/dscr_dev_end.sv
`timescale 1ns/100ps
module dscr_dev_end #(
  parameter int FRAME_BITS = dscr_pkg::FRAME_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial link
  dscr_link_if.dev link,
  // converter core controls
  output logic holdStageBypass,
  output dscr_pkg::dscr_rate_t updateRate,
  output logic [dscr_pkg::DATA_W-1:0] setupWord,
  // framing status
  output logic frameError
);
  import dscr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  generate
    if (FRAME_BITS < RW_BIT + 1 || FRAME_BITS >= (1 << CNT_W) - 1) begin : g_bad_len
      $error("frame length outside what the bit counter serves");
    end
  endgenerate

  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  typedef enum logic {
    DEV_IDLE,
    DEV_SHIFT
  } dscr_dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] sclkSync_q, sclkSync_d;
  logic [1:0] syncNSync_q, syncNSync_d;
  logic [1:0] mosiSync_q, mosiSync_d;
  logic sclkPrev_q, sclkPrev_d;
  logic syncNPrev_q, syncNPrev_d;

  always_comb begin
    sclkSync_d = {sclkSync_q[0], link.sclk};
    syncNSync_d = {syncNSync_q[0], link.syncN};
    mosiSync_d = {mosiSync_q[0], link.mosi};
    sclkPrev_d = sclkSync_q[1];
    syncNPrev_d = syncNSync_q[1];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclkSync_q <= '0;
      syncNSync_q <= '1;
      mosiSync_q <= '0;
      sclkPrev_q <= 1'b0;
      syncNPrev_q <= 1'b1;
    end else begin
      sclkSync_q <= sclkSync_d;
      syncNSync_q <= syncNSync_d;
      mosiSync_q <= mosiSync_d;
      sclkPrev_q <= sclkPrev_d;
      syncNPrev_q <= syncNPrev_d;
    end
  end

  // edges seen only on the second stage
  logic sclkRise, sclkFall, frameStart, frameEnd;

  always_comb begin
    sclkRise = sclkSync_q[1] & ~sclkPrev_q;
    sclkFall = ~sclkSync_q[1] & sclkPrev_q;
    frameStart = ~syncNSync_q[1] & syncNPrev_q;
    frameEnd = syncNSync_q[1] & ~syncNPrev_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine and register

  dscr_dev_state_t state_q, state_d;
  logic [CNT_W-1:0] bitCnt_q, bitCnt_d;
  logic [RW_BIT:0] rxShift_q, rxShift_d;
  logic [RW_BIT:0] txShift_q, txShift_d;
  logic [RW_BIT:0] pending_q, pending_d;
  logic sdo_q, sdo_d;
  logic hold_q, hold_d;
  dscr_rate_t rate_q, rate_d;
  logic frameErr_q, frameErr_d;
  logic addrHit;
  logic isRead;

  always_comb begin
    addrHit = rxShift_q[ADDR_HI:ADDR_LO] == SETUP2_ADDR;
    isRead = rxShift_q[RW_BIT];
  end

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    rxShift_d = rxShift_q;
    txShift_d = txShift_q;
    pending_d = pending_q;
    sdo_d = sdo_q;
    hold_d = hold_q;
    rate_d = rate_q;
    frameErr_d = 1'b0;
    case (state_q)
      DEV_IDLE: begin
        if (frameStart) begin
          state_d = DEV_SHIFT;
          bitCnt_d = '0;
          // readback word goes out once, in the frame after the read
          txShift_d = pending_q;
          pending_d = '0;
        end
      end
      DEV_SHIFT: begin
        if (sclkRise) begin
          sdo_d = txShift_q[RW_BIT];
          txShift_d = {txShift_q[RW_BIT-1:0], 1'b0};
        end
        if (sclkFall) begin
          rxShift_d = {rxShift_q[RW_BIT-1:0], mosiSync_q[1]};
          // saturate so a runaway clock cannot wrap back to a legal count
          if (bitCnt_q != CNT_MAX) begin
            bitCnt_d = bitCnt_q + CNT_W'(1);
          end
        end
        if (frameEnd) begin
          state_d = DEV_IDLE;
          sdo_d = 1'b0;
          if (bitCnt_q != FRAME_CNT) begin
            // short or long frames change nothing but the pending readback, dropped at frame start
            frameErr_d = 1'b1;
          end else if (addrHit) begin
            if (isRead) begin
              pending_d = {1'b1, SETUP2_ADDR, setup_word(hold_q, rate_q)};
            end else begin
              hold_d = rxShift_q[HOLD_BIT];
              rate_d = dscr_rate_t'(rxShift_q[RATE_HI:RATE_LO]);
            end
          end
        end
      end
      default: begin
        state_d = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= DEV_IDLE;
      bitCnt_q <= '0;
      rxShift_q <= '0;
      txShift_q <= '0;
      pending_q <= '0;
      sdo_q <= 1'b0;
      hold_q <= SETUP2_RESET[HOLD_BIT];
      rate_q <= dscr_rate_t'(SETUP2_RESET[RATE_HI:RATE_LO]);
      frameErr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      rxShift_q <= rxShift_d;
      txShift_q <= txShift_d;
      pending_q <= pending_d;
      sdo_q <= sdo_d;
      hold_q <= hold_d;
      rate_q <= rate_d;
      frameErr_q <= frameErr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // reserved bits are not stored; they always read their fixed values
  always_comb begin
    setupWord = setup_word(hold_q, rate_q);
    holdStageBypass = hold_q;
    updateRate = rate_q;
    frameError = frameErr_q;
    link.miso = sdo_q;
  end

endmodule

// ### rtl/dscr_host_end.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module dscr_host_end #(
  parameter int SCLK_HALF = dscr_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [dscr_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [dscr_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial link
  dscr_link_if.host link
);
  import dscr_pkg::*;

  // miso crosses two flops plus device launch delay within one sclk period
  generate
    if (SCLK_HALF < 3 || SCLK_HALF > 255) begin : g_bad_half
      $error("half period must lie in 3..255 cycles");
    end
  endgenerate

  localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF - 1);
  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(FRAME_BITS);

  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_HIGH,
    H_LOW,
    H_GAP
  } dscr_host_state_t;

  // write from the bus only changes data field, fixes reserved bits
  function automatic logic [RW_BIT:0] fix_frame(input logic [RW_BIT:0] f);
    logic [RW_BIT:0] r;
    r = f;
    if (!f[RW_BIT] && f[ADDR_HI:ADDR_LO] == SETUP2_ADDR) begin
      r[DATA_W-1:0] = setup_word(f[HOLD_BIT], f[RATE_HI:RATE_LO]);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register slave

  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [AXI_ADDR_W-1:0] awAddr_q, awAddr_d, rdAddr;
  logic [31:0] wData_q, wData_d, frame_q, frame_d, rdata_d, frameMerged;
  logic [3:0] wStrb_q, wStrb_d;
  logic bvalid_d, rvalid_d, done_q, done_d, wrFire, startReq, doneSet, busy;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] reply_q, reply_d;
  dscr_host_state_t hst_q, hst_d;

  always_comb begin
    awready = ~awHeld_q;
    wready = ~wHeld_q;
    arready = ~rvalid;
    busy = hst_q != H_IDLE;
    wrFire = awHeld_q & wHeld_q & ~bvalid;
    for (int i = 0; i < 4; i++) begin
      frameMerged[8*i +: 8] = wStrb_q[i] ? wData_q[8*i +: 8] : frame_q[8*i +: 8];
    end
    startReq = wrFire & (awAddr_q == OFS_FRAME) & ~busy & (|wStrb_q);
    awHeld_d = awHeld_q | awvalid;
    awAddr_d = (awvalid & ~awHeld_q) ? awaddr : awAddr_q;
    wHeld_d = wHeld_q | wvalid;
    wData_d = (wvalid & ~wHeld_q) ? wdata : wData_q;
    wStrb_d = (wvalid & ~wHeld_q) ? wstrb : wStrb_q;
    bvalid_d = bvalid & ~bready;
    bresp_d = bresp;
    frame_d = startReq ? fix_frame(frameMerged) : frame_q;
    // a frame ending in the clearing cycle keeps the flag
    done_d = doneSet | (done_q & ~(wrFire & awAddr_q == OFS_STATUS & wStrb_q[0]
      & wData_q[STAT_DONE]));
    if (wrFire) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awAddr_q == OFS_FRAME || awAddr_q == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    rdAddr = araddr;
    rvalid_d = rvalid & ~rready;
    rdata_d = rdata;
    rresp_d = rresp;
    if (arvalid & ~rvalid) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (rdAddr)
        OFS_FRAME: rdata_d = frame_q;
        OFS_STATUS: rdata_d = {30'h0000_0000, done_q, busy};
        OFS_REPLY: rdata_d = reply_q;
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      frame_q <= '0;
      done_q <= 1'b0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
      frame_q <= frame_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial engine, sclk from a divider

  logic [1:0] misoSync_q, misoSync_d;
  logic [7:0] div_q, div_d;
  logic [CNT_W-1:0] bits_q, bits_d;
  logic [RW_BIT:0] tx_q, tx_d, rx_q, rx_d;
  logic sclk_q, sclk_d, syncN_q, syncN_d, mosi_q, mosi_d, tick;

  always_comb begin
    misoSync_d = {misoSync_q[0], link.miso};
    tick = div_q == '0;
    hst_d = hst_q;
    div_d = tick ? HALF_LOAD : div_q - 8'h01;
    bits_d = bits_q;
    tx_d = tx_q;
    rx_d = rx_q;
    sclk_d = sclk_q;
    syncN_d = syncN_q;
    mosi_d = mosi_q;
    reply_d = reply_q;
    doneSet = 1'b0;
    case (hst_q)
      H_IDLE: begin
        div_d = HALF_LOAD;
        if (startReq) begin
          tx_d = fix_frame(frameMerged);
          bits_d = '0;
          syncN_d = 1'b0;
          hst_d = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (tick) begin
          // late sample: previous rise's bit has crossed the synchroniser
          if (hst_q == H_LOW) begin
            rx_d = {rx_q[RW_BIT-1:0], misoSync_q[1]};
          end
          if (hst_q == H_LOW && bits_q == FRAME_CNT) begin
            syncN_d = 1'b1;
            hst_d = H_GAP;
          end else begin
            sclk_d = 1'b1;
            mosi_d = tx_q[RW_BIT];
            tx_d = {tx_q[RW_BIT-1:0], 1'b0};
            bits_d = bits_q + CNT_W'(1);
            hst_d = H_HIGH;
          end
        end
      end
      H_HIGH: begin
        if (tick) begin
          sclk_d = 1'b0;
          hst_d = H_LOW;
        end
      end
      H_GAP: begin
        if (tick) begin
          reply_d = rx_q;
          doneSet = 1'b1;
          hst_d = H_IDLE;
        end
      end
      default: begin
        hst_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      misoSync_q <= '0;
      hst_q <= H_IDLE;
      div_q <= '0;
      bits_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      sclk_q <= 1'b0;
      syncN_q <= 1'b1;
      mosi_q <= 1'b0;
      reply_q <= '0;
    end else begin
      misoSync_q <= misoSync_d;
      hst_q <= hst_d;
      div_q <= div_d;
      bits_q <= bits_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      sclk_q <= sclk_d;
      syncN_q <= syncN_d;
      mosi_q <= mosi_d;
      reply_q <= reply_d;
    end
  end

  always_comb begin
    link.sclk = sclk_q;
    link.syncN = syncN_q;
    link.mosi = mosi_q;
  end

endmodule

// ### rtl/dscr_link_if.sv
`timescale 1ns/100ps
interface dscr_link_if;
  // serial clock, idles low
  logic sclk;
  // frame select, active low
  logic syncN;
  // controller to device data
  logic mosi;
  // device to controller data
  logic miso;

  modport dev (
    input sclk,
    input syncN,
    input mosi,
    output miso
  );

  modport host (
    output sclk,
    output syncN,
    output mosi,
    input miso
  );
endinterface

// ### rtl/dscr_pkg.sv
package dscr_pkg;

  // frame layout
  localparam int FRAME_BITS = 32;
  localparam int RW_BIT = 31;
  localparam int ADDR_HI = 30;
  localparam int ADDR_LO = 24;
  localparam int DATA_W = 24;
  localparam int CNT_W = 6;

  // second setup word
  localparam logic [6:0] SETUP2_ADDR = 7'h06;
  localparam logic [DATA_W-1:0] SETUP2_RESET = 24'h00_0040;
  localparam int HOLD_BIT = 7;
  localparam int RATE_HI = 5;
  localparam int RATE_LO = 4;

  // update rate select, in field order
  typedef enum logic [1:0] {
    RATE_0P8M,
    RATE_1P05M,
    RATE_0P7M,
    RATE_0P95M
  } dscr_rate_t;

  // link timing
  localparam int SYS_CLK_NS = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);

  // controller register map
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] OFS_FRAME = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] OFS_REPLY = 4'h8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // data field with reserved bits forced to their fixed values
  function automatic logic [DATA_W-1:0] setup_word(input logic hold, input logic [1:0] rate);
    logic [DATA_W-1:0] w;
    w = SETUP2_RESET;
    w[HOLD_BIT] = hold;
    w[RATE_HI:RATE_LO] = rate;
    return w;
  endfunction

endpackage

// ### tb/dscr_link_assertions.sv
`timescale 1ns/100ps
module dscr_link_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic syncN,
  input wire logic mosi,
  input wire logic miso
);
  logic [5:0] fallCnt_q;
  logic [5:0] fallCnt_d;
  logic sclkPrev_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////
  // falls of sclk inside the current frame
  always_comb begin
    fallCnt_d = fallCnt_q;
    if (srst || syncN) begin
      fallCnt_d = 6'h00;
    end else if (sclkPrev_q && !sclk) begin
      fallCnt_d = fallCnt_q + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    sclkPrev_q <= sclk;
    fallCnt_q <= fallCnt_d;
  end

  ////////////////////////////////////////////////////////////////
  sequence lead_half;
    !sclk [*4] ##1 sclk;
  endsequence

  sequence high_half;
    sclk [*4] ##1 !sclk;
  endsequence

  chk_sclk_idle_low: assert property (syncN |-> !sclk)
    else $error("sclk moved outside a frame");
  // device lags the frame select through its synchroniser, so allow a few cycles
  chk_miso_idle_zero: assert property (syncN [*4] |-> !miso)
    else $error("miso not zero between frames");
  chk_mosi_stable_fall: assert property ($fell(sclk) |-> $stable(mosi))
    else $error("mosi changed at the sampling edge");
  chk_lead_half: assert property ($fell(syncN) |-> lead_half)
    else $error("first sclk rise not one half after frame start");
  chk_sclk_high_half: assert property ($rose(sclk) |-> high_half)
    else $error("sclk high phase has wrong length");
  chk_frame_bits: assert property ($rose(syncN) && !$past(srst) |-> fallCnt_q == 6'h20)
    else $error("frame did not carry 32 sclk falls");
  chk_frame_gap: assert property ($rose(syncN) |-> syncN [*4])
    else $error("frames too close together");
  // lead half plus 32 full sclk periods, last low half included
  chk_frame_length: assert property ($fell(syncN) |-> ##260 $rose(syncN))
    else $error("frame select low for wrong number of cycles");
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  import dscr_pkg::*;

  typedef struct packed {
    logic [23:0] data;
    logic hold;
    dscr_rate_t rate;
    logic [23:0] word;
  } dscr_row_t;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr = '0;
  logic [AXI_ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, holdStageBypass, frameError;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  dscr_rate_t updateRate;
  logic [23:0] setupWord;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int errPulses = 0;
  int errPulsesLong = 0;
  int framesSent = 0;
  logic frameErrorLong;
  logic [23:0] setupWordLong;
  // reserved bits are dirtied on purpose in every row (bit 6 cleared, all set in the last row); the host must clean them
  dscr_row_t rows [4] = '{
    '{24'h00_0010, 1'b0, RATE_1P05M, 24'h00_0050},
    '{24'h00_0000, 1'b0, RATE_0P8M, 24'h00_0040},
    '{24'h00_00A0, 1'b1, RATE_0P7M, 24'h00_00E0},
    '{24'hFF_FFBF, 1'b1, RATE_0P95M, 24'h00_00F0}
  };

  dscr_link_if link ();
  dscr_link_if linkLong ();

  // a device built for 33-bit frames must refuse every 32-bit frame it overhears
  assign linkLong.sclk = link.sclk;
  assign linkLong.syncN = link.syncN;
  assign linkLong.mosi = link.mosi;

  dscr_dev_end u_dscr_dev_end (.sys_clk(sys_clk), .srst(srst), .link(link.dev),
    .holdStageBypass(holdStageBypass), .updateRate(updateRate), .setupWord(setupWord),
    .frameError(frameError));

  dscr_dev_end #(.FRAME_BITS(33)) u_dscr_dev_end_long (.sys_clk(sys_clk), .srst(srst),
    .link(linkLong.dev), .holdStageBypass(), .updateRate(), .setupWord(setupWordLong),
    .frameError(frameErrorLong));

  dscr_host_end u_dscr_host_end (.sys_clk(sys_clk), .srst(srst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(link.host));

  dscr_link_assertions u_dscr_link_assertions (.sys_clk(sys_clk), .srst(srst),
    .sclk(link.sclk), .syncN(link.syncN), .mosi(link.mosi), .miso(link.miso));

  ////////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (frameError === 1'b1) begin
      errPulses++;
    end
    if (frameErrorLong === 1'b1) begin
      errPulsesLong++;
    end
    cycles++;
    // roughly 14 frames of 300 cycles fit well below this
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // poll until the frame is done, then clear the flag
  task automatic wait_done;
    logic [31:0] s;
    logic [1:0] r;
    s = '0;
    while (s[STAT_DONE] !== 1'b1) axi_rd(OFS_STATUS, s, r);
    axi_wr(OFS_STATUS, 32'h0000_0002, r);
  endtask

  // one frame on the link, waiting for done and clearing it
  task automatic send_frame(input logic [31:0] f);
    logic [1:0] r;
    axi_wr(OFS_FRAME, f, r);
    chk(32'(r), 32'(RESP_OKAY));
    framesSent++;
    wait_done();
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      send_frame({1'b0, SETUP2_ADDR, rows[i].data});
      chk(32'(holdStageBypass), 32'(rows[i].hold));
      chk(32'(updateRate), 32'(rows[i].rate));
      chk(32'(setupWord), 32'(rows[i].word));
      send_frame({1'b1, SETUP2_ADDR, 24'h00_0000});
      // a frame right after a write carries nothing back
      axi_rd(OFS_REPLY, d, r);
      chk(d, 32'h0000_0000);
      send_frame({1'b1, SETUP2_ADDR, 24'h00_0000});
      axi_rd(OFS_REPLY, d, r);
      chk(d, {1'b1, SETUP2_ADDR, rows[i].word});
      chk(32'(setupWord), 32'(rows[i].word));
    end
    // another address must not touch the word
    send_frame({1'b0, 7'h05, 24'h00_0000});
    chk(32'(setupWord), 32'h0000_00F0);
    axi_rd(4'hC, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0000_0000);
    axi_wr(OFS_REPLY, 32'h0000_0000, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // a frame write while the link is busy is answered but dropped
    axi_wr(OFS_FRAME, {1'b0, SETUP2_ADDR, 24'h00_0080}, r);
    framesSent++;
    axi_rd(OFS_STATUS, d, r);
    chk(d, 32'h0000_0001);
    axi_wr(OFS_FRAME, {1'b0, SETUP2_ADDR, 24'h00_0030}, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(OFS_FRAME, d, r);
    chk(d, {1'b0, SETUP2_ADDR, 24'h00_00C0});
    wait_done();
    axi_rd(OFS_STATUS, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(setupWord), 32'h0000_00C0);
    chk(32'(updateRate), 32'(RATE_0P8M));
    chk(32'(errPulsesLong), 32'(framesSent));
    chk(32'(setupWordLong), 32'(SETUP2_RESET));
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk(32'(setupWord), 32'h0000_0040);
    chk(32'(holdStageBypass), 32'h0000_0000);
    chk(32'(updateRate), 32'(RATE_0P8M));
    chk(32'(errPulses), 32'h0000_0000);
    axi_rd(OFS_REPLY, d, r);
    chk(d, 32'h0000_0000);
    end_of_test();
  end
endmodule
